// ===== logic/ebc_bus_ctrl.sv
// External bus cycle controller: reset sequencing, code routing, width and waits.
// Assumes synchronous pin inputs and a 125 MHz clk_in; bus clock is clk_in / 2.
// Overview of operation
// - Reset pin low for 16 state times puts the block into reset.
// - Reset pin release realigns the bus clock and starts a 10 state-time sequence.
// - The sequence clears the status word and loads config bytes 2018H, 201AH, and 201CH when bit 7 of 201AH enables it.
// - Sequence end starts execution at address 2080H.
// - Select high sends the code region on chip, low sends it off chip.
// - The select level is latched in reset and used afterwards.
// - Dynamic width mode: width pin low gives 8-bit, high gives 16-bit cycles.
// - Fixed modes give all 8-bit or all 16-bit cycles.
// - Ready low before falling edge adds waits until a rising edge sees it high.
// - Ready is ignored outside external accesses.
// - Wait states per cycle are capped by the configuration registers.
// - Unused ready or width pin works as a plain low-speed port pin.
// - Bus clock output runs with 50 percent duty cycle.
// - 16-bit cycles select bytes with address LSB and high byte enable.
// - Write strobe pulses on every write, or only even-byte writes in low mode.
// - Address-valid strobe returns high at the end of each access; it stays low between the two byte cycles of an 8-bit word.
`timescale 1ns/1ps
`include "ebc_defines.svh"

module ebc_bus_ctrl (
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              reset_pin_n_in,
  input  wire logic              external_access_select_in,
  input  wire logic              ready_pin_in,
  output logic                   ready_pin_out,
  output logic                   ready_pin_oe_out,
  input  wire logic              bus_width_pin_in,
  output logic                   bus_width_pin_out,
  output logic                   bus_width_pin_oe_out,
  input  wire logic [1:0]        low_speed_io_data_in,
  input  wire logic [1:0]        low_speed_io_oe_in,
  output logic [1:0]             low_speed_io_value_out,
  input  wire logic              req_valid_in,
  input  wire ebc_pkg::ebc_req_t req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [15:0]            rsp_rdata_out,
  output logic                   int_sel_out,
  output logic [23:0]            int_addr_out,
  input  wire logic [15:0]       int_rdata_in,
  input  wire logic [15:0]       ext_data_in,
  output ebc_pkg::ebc_bus_pins_t bus_out,
  output logic                   bus_clock_output_out,
  output logic                   in_reset_out,
  output logic                   exec_start_out,
  output logic [23:0]            exec_addr_out,
  input  wire logic              psw_load_in,
  input  wire logic [15:0]       psw_in,
  output logic [15:0]            program_status_word_out,
  output logic [7:0]             chip_config_reg_0_out,
  output logic [7:0]             chip_config_reg_1_out,
  output logic [7:0]             chip_config_byte_2_out
);
  import ebc_pkg::*;

  // Width of one cycle from the two config bits and the synchronised pin
  function automatic logic width16(input logic [7:0] c0, input logic [7:0] c1, input logic bw);
    case ({c0[`EBC_CCR0_BW], c1[`EBC_CHIP_CONFIG_REG_1_BW]})
      2'b11:   width16 = bw;
      2'b01:   width16 = 1'b0;
      default: width16 = 1'b1;
    endcase
  endfunction

  // Latched select steers the fixed code region on chip
  function automatic logic is_internal(input logic ea, input logic [23:0] a);
    is_internal = ea && (a >= `EBC_CODE_LO) && (a <= `EBC_CODE_HI);
  endfunction

  ebc_rst_st_t   rst_st_r, rst_st_nxt;
  ebc_bus_st_t   bst_r, bst_nxt;
  logic [5:0]    low_cnt_r, low_cnt_nxt;
  logic [4:0]    seq_cnt_r, seq_cnt_nxt;
  logic [1:0]    step_r, step_nxt;
  logic          seq_pend_r, seq_pend_nxt;
  logic [7:0]    ccr0_r, ccr0_nxt, chip_config_reg_1_r, chip_config_reg_1_nxt, ccb2_r, ccb2_nxt;
  logic [15:0]   psw_r, psw_nxt;
  logic          ea_r, ea_nxt;
  logic          bclk_r, bclk_nxt;
  logic          exec_start_r, exec_start_nxt;
  logic [23:0]   exec_addr_r, exec_addr_nxt;
  ebc_req_t      cur_r, cur_nxt;
  logic          owner_seq_r, owner_seq_nxt;
  logic          is16_r, is16_nxt, second_r, second_nxt, stall_r, stall_nxt;
  logic [2:0]    wcnt_r, wcnt_nxt;
  logic [15:0]   rdata_r, rdata_nxt;
  logic          rsp_v_r, rsp_v_nxt, int_sel_r, int_sel_nxt;
  ebc_bus_pins_t pins_r, pins_nxt;
  logic          rdy_m_r, rdy_s_r, bw_m_r, bw_s_r;
  logic [1:0]    low_speed_io_r;
  logic          in_rst, rise, fall, seq_req_v, sel_v, acc, finish;
  logic          rdy_en, bw_dyn;
  ebc_req_t      sel_req;
  logic [2:0]    wmax;
  logic [7:0]    seq_byte;

  assign in_rst = (rst_st_r == RS_RESET);
  assign rise   = !bclk_r && !in_rst;
  assign fall   = bclk_r;
  assign rdy_en = ccr0_r[`EBC_CCR0_RDY];
  assign bw_dyn = ccr0_r[`EBC_CCR0_BW] && chip_config_reg_1_r[`EBC_CHIP_CONFIG_REG_1_BW];
  assign wmax   = {chip_config_reg_1_r[`EBC_CHIP_CONFIG_REG_1_WS_HI], ccr0_r[`EBC_CCR0_WS_LO +: 2]};

  // Sequencer requests take priority; the core is only served once running
  assign seq_req_v = (rst_st_r == RS_SEQ) && (step_r != 2'd3) && !seq_pend_r;
  always_comb begin
    sel_req = req_in;
    sel_v   = req_valid_in && (rst_st_r == RS_RUN);
    if (rst_st_r == RS_SEQ) begin
      sel_v         = seq_req_v;
      sel_req.write = 1'b0;
      sel_req.word  = 1'b0;
      sel_req.wdata = 16'h0000;
      case (step_r)
        2'd0:    sel_req.addr = {`EBC_CODE_PAGE, `EBC_CCB0_ADDR};
        2'd1:    sel_req.addr = {`EBC_CODE_PAGE, `EBC_CCB1_ADDR};
        default: sel_req.addr = {`EBC_CODE_PAGE, `EBC_CCB2_ADDR};
      endcase
    end
  end

  // External cycles start only on a state-time boundary, internal ones at once
  assign acc = sel_v && (bst_r == BUS_IDLE) && !in_rst &&
               (is_internal(ea_r, sel_req.addr) || rise);
  assign req_ready_out = (rst_st_r == RS_RUN) && (bst_r == BUS_IDLE) &&
                         (is_internal(ea_r, req_in.addr) || rise);
  assign seq_byte = rdata_r[7:0];

  // Reset detection, start-up sequence and configuration loading
  always_comb begin
    rst_st_nxt     = rst_st_r;
    low_cnt_nxt    = reset_pin_n_in ? 6'd0 : low_cnt_r + 6'd1;
    seq_cnt_nxt    = seq_cnt_r;
    step_nxt       = step_r;
    seq_pend_nxt   = seq_pend_r;
    ccr0_nxt       = ccr0_r;
    chip_config_reg_1_nxt       = chip_config_reg_1_r;
    ccb2_nxt       = ccb2_r;
    psw_nxt        = psw_load_in ? psw_in : psw_r;
    ea_nxt         = ea_r;
    bclk_nxt       = !bclk_r;
    exec_start_nxt = 1'b0;
    exec_addr_nxt  = exec_addr_r;
    case (rst_st_r)
      RS_RESET: begin
        bclk_nxt    = 1'b0;
        low_cnt_nxt = 6'd0;
        ea_nxt      = external_access_select_in;
        ccr0_nxt    = `EBC_CCR0_RST;
        chip_config_reg_1_nxt    = `EBC_CHIP_CONFIG_REG_1_RST;
        ccb2_nxt    = 8'h00;
        psw_nxt     = 16'h0000;
        if (reset_pin_n_in) begin
          rst_st_nxt  = RS_SEQ;
          seq_cnt_nxt = 5'd0;
          step_nxt    = 2'd0;
        end
      end
      RS_SEQ: begin
        psw_nxt = 16'h0000;
        if (seq_cnt_r != 5'(`EBC_SEQ_CLKS)) begin
          seq_cnt_nxt = seq_cnt_r + 5'd1;
        end
        if (acc) begin
          seq_pend_nxt = 1'b1;
        end
        if (rsp_v_r && owner_seq_r) begin
          seq_pend_nxt = 1'b0;
          step_nxt     = step_r + 2'd1;
          case (step_r)
            2'd0: ccr0_nxt = seq_byte;
            2'd1: begin
              chip_config_reg_1_nxt = seq_byte;
              if (!seq_byte[`EBC_CHIP_CONFIG_REG_1_CCB2_EN]) begin
                step_nxt = 2'd3;
              end
            end
            default: ccb2_nxt = seq_byte;
          endcase
        end
        if ((seq_cnt_r == 5'(`EBC_SEQ_CLKS)) && (step_r == 2'd3)) begin
          rst_st_nxt     = RS_RUN;
          exec_start_nxt = 1'b1;
          exec_addr_nxt  = {`EBC_CODE_PAGE, `EBC_START_ADDR};
        end
      end
      RS_RUN:  ;
      default: rst_st_nxt = RS_RESET;
    endcase
    if (!in_rst && (low_cnt_r == 6'(`EBC_RST_LOW_CLKS - 1)) && !reset_pin_n_in) begin
      rst_st_nxt = RS_RESET;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_st_r     <= RS_RESET;
      low_cnt_r    <= 6'd0;
      seq_cnt_r    <= 5'd0;
      step_r       <= 2'd0;
      seq_pend_r   <= 1'b0;
      ccr0_r       <= `EBC_CCR0_RST;
      chip_config_reg_1_r       <= `EBC_CHIP_CONFIG_REG_1_RST;
      ccb2_r       <= 8'h00;
      psw_r        <= 16'h0000;
      ea_r         <= 1'b0;
      bclk_r       <= 1'b0;
      exec_start_r <= 1'b0;
      exec_addr_r  <= 24'h000000;
    end else begin
      rst_st_r     <= rst_st_nxt;
      low_cnt_r    <= low_cnt_nxt;
      seq_cnt_r    <= seq_cnt_nxt;
      step_r       <= step_nxt;
      seq_pend_r   <= seq_pend_nxt;
      ccr0_r       <= ccr0_nxt;
      chip_config_reg_1_r       <= chip_config_reg_1_nxt;
      ccb2_r       <= ccb2_nxt;
      psw_r        <= psw_nxt;
      ea_r         <= ea_nxt;
      bclk_r       <= bclk_nxt;
      exec_start_r <= exec_start_nxt;
      exec_addr_r  <= exec_addr_nxt;
    end
  end

  // Pin synchronisers and port-pin sampling; second flops alone feed logic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdy_m_r <= 1'b1;
      rdy_s_r <= 1'b1;
      bw_m_r  <= 1'b1;
      bw_s_r  <= 1'b1;
      low_speed_io_r  <= 2'b00;
    end else begin
      rdy_m_r <= ready_pin_in;
      rdy_s_r <= rdy_m_r;
      bw_m_r  <= bus_width_pin_in;
      bw_s_r  <= bw_m_r;
      low_speed_io_r  <= {bus_width_pin_in, ready_pin_in};
    end
  end

  // Bus cycle engine: address, data, waits, byte lanes and strobes
  always_comb begin
    bst_nxt       = bst_r;
    cur_nxt       = cur_r;
    owner_seq_nxt = owner_seq_r;
    is16_nxt      = is16_r;
    second_nxt    = second_r;
    stall_nxt     = stall_r;
    wcnt_nxt      = wcnt_r;
    rdata_nxt     = rdata_r;
    rsp_v_nxt     = 1'b0;
    int_sel_nxt   = 1'b0;
    finish        = 1'b0;
    case (bst_r)
      BUS_IDLE: if (acc) begin
        cur_nxt       = sel_req;
        owner_seq_nxt = (rst_st_r == RS_SEQ);
        second_nxt    = 1'b0;
        if (is_internal(ea_r, sel_req.addr)) begin
          bst_nxt     = BUS_INTR;
          int_sel_nxt = 1'b1;
        end else begin
          bst_nxt = BUS_ADDR;
        end
      end
      BUS_INTR: begin
        rdata_nxt = (!cur_r.word && cur_r.addr[0]) ? {8'h00, int_rdata_in[15:8]}
                                                   : int_rdata_in;
        rsp_v_nxt = 1'b1;
        bst_nxt   = BUS_IDLE;
      end
      BUS_ADDR: if (rise) begin
        bst_nxt   = BUS_DATA;
        is16_nxt  = width16(ccr0_r, chip_config_reg_1_r, bw_s_r);
        stall_nxt = 1'b0;
        wcnt_nxt  = 3'd0;
      end
      BUS_DATA: begin
        if (fall) begin
          stall_nxt = rdy_en && !rdy_s_r;
        end
        if (rise) begin
          if (stall_r && (wmax != 3'd0)) begin
            bst_nxt  = BUS_WAIT;
            wcnt_nxt = 3'd1;
          end else begin
            finish = 1'b1;
          end
        end
      end
      BUS_WAIT: if (rise) begin
        if (rdy_s_r || (wcnt_r == wmax)) begin
          finish = 1'b1;
        end else begin
          wcnt_nxt = wcnt_r + 3'd1;
        end
      end
      default: bst_nxt = BUS_IDLE;
    endcase
    // End of an external cycle: capture lanes, maybe run the high byte
    if (finish) begin
      if (is16_r) begin
        rdata_nxt = (!cur_r.word && cur_r.addr[0]) ? {8'h00, ext_data_in[15:8]}
                                                   : ext_data_in;
      end else if (second_r) begin
        rdata_nxt[15:8] = ext_data_in[7:0];
      end else begin
        rdata_nxt = {8'h00, ext_data_in[7:0]};
      end
      if (!is16_r && cur_r.word && !second_r) begin
        second_nxt = 1'b1;
        bst_nxt    = BUS_ADDR;
      end else begin
        rsp_v_nxt = 1'b1;
        bst_nxt   = BUS_IDLE;
      end
    end
    if (in_rst) begin
      bst_nxt = BUS_IDLE;
    end
  end

  // Pin values follow the next state so they line up with it
  always_comb begin
    pins_nxt                    = '0;
    pins_nxt.addr               = {cur_nxt.addr[23:1], cur_nxt.addr[0] | second_nxt};
    pins_nxt.byte_address_lsb   = pins_nxt.addr[0];
    pins_nxt.high_byte_enable_n = !(is16_nxt && (cur_nxt.word || cur_nxt.addr[0]));
    pins_nxt.rd_n               = 1'b1;
    pins_nxt.wr_n               = 1'b1;
    pins_nxt.addr_strobe        = ccr0_r[`EBC_CCR0_ADV];
    pins_nxt.data               = cur_nxt.wdata;
    if (!is16_nxt && second_nxt) begin
      pins_nxt.data = {8'h00, cur_nxt.wdata[15:8]};
    end else if (is16_nxt && !cur_nxt.word && cur_nxt.addr[0]) begin
      pins_nxt.data = {cur_nxt.wdata[7:0], cur_nxt.wdata[7:0]};
    end
    if (bst_nxt == BUS_ADDR) begin
      pins_nxt.addr_strobe = !ccr0_r[`EBC_CCR0_ADV];
    end else if ((bst_nxt == BUS_DATA) || (bst_nxt == BUS_WAIT)) begin
      pins_nxt.addr_strobe = 1'b0;
      pins_nxt.rd_n        = cur_nxt.write;
      pins_nxt.data_oe     = cur_nxt.write;
      pins_nxt.wr_n        = !(cur_nxt.write &&
                               (!ccr0_r[`EBC_CCR0_WRL] || !pins_nxt.addr[0]));
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bst_r       <= BUS_IDLE;
      cur_r       <= '0;
      owner_seq_r <= 1'b0;
      is16_r      <= 1'b1;
      second_r    <= 1'b0;
      stall_r     <= 1'b0;
      wcnt_r      <= 3'd0;
      rdata_r     <= 16'h0000;
      rsp_v_r     <= 1'b0;
      int_sel_r   <= 1'b0;
      pins_r      <= '{addr: 24'h000000, data: 16'h0000, data_oe: 1'b0, default: 1'b1};
    end else begin
      bst_r       <= bst_nxt;
      cur_r       <= cur_nxt;
      owner_seq_r <= owner_seq_nxt;
      is16_r      <= is16_nxt;
      second_r    <= second_nxt;
      stall_r     <= stall_nxt;
      wcnt_r      <= wcnt_nxt;
      rdata_r     <= rdata_nxt;
      rsp_v_r     <= rsp_v_nxt;
      int_sel_r   <= int_sel_nxt;
      pins_r      <= pins_nxt;
    end
  end

  // Unused function pins fall back to plain port pins
  assign ready_pin_out           = low_speed_io_data_in[0];
  assign ready_pin_oe_out        = !rdy_en && low_speed_io_oe_in[0];
  assign bus_width_pin_out       = low_speed_io_data_in[1];
  assign bus_width_pin_oe_out    = !bw_dyn && low_speed_io_oe_in[1];
  assign low_speed_io_value_out  = low_speed_io_r;
  assign rsp_valid_out           = rsp_v_r && !owner_seq_r;
  assign rsp_rdata_out           = rdata_r;
  assign int_sel_out             = int_sel_r;
  assign int_addr_out            = cur_r.addr;
  assign bus_out                 = pins_r;
  assign bus_clock_output_out    = bclk_r;
  assign in_reset_out            = in_rst;
  assign exec_start_out          = exec_start_r;
  assign exec_addr_out           = exec_addr_r;
  assign program_status_word_out = psw_r;
  assign chip_config_reg_0_out   = ccr0_r;
  assign chip_config_reg_1_out   = chip_config_reg_1_r;
  assign chip_config_byte_2_out  = ccb2_r;

  // Checks beside the logic they guard
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_stall_rise;
    (bst_r == BUS_WAIT) && rise && !rdy_s_r && (wcnt_r < wmax);
  endsequence
  sequence s_seq_start;
    (rst_st_r == RS_RESET) ##1 (rst_st_r == RS_SEQ);
  endsequence

  property p_rst_entry;
    (!in_rst && (rst_st_nxt == RS_RESET)) |-> (low_cnt_r == 6'(`EBC_RST_LOW_CLKS - 1));
  endproperty
  a_rst_entry: assert property (p_rst_entry) else $error("reset entered too early");
  property p_realign;
    s_seq_start |-> !bclk_r && (seq_cnt_r == 5'd0);
  endproperty
  a_realign: assert property (p_realign) else $error("bus clock not realigned");
  property p_seq_len;
    exec_start_r |-> ($past(seq_cnt_r) == 5'(`EBC_SEQ_CLKS)) && (rst_st_r == RS_RUN);
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence length wrong");
  property p_psw_clear;
    (rst_st_r == RS_SEQ) |=> (psw_r == 16'h0000) || (rst_st_r == RS_RUN);
  endproperty
  a_psw_clear: assert property (p_psw_clear) else $error("status word not cleared");
  property p_start;
    exec_start_r |-> (exec_addr_r == {`EBC_CODE_PAGE, `EBC_START_ADDR});
  endproperty
  a_start: assert property (p_start) else $error("wrong start address");
  property p_route;
    int_sel_r |-> ea_r && (int_addr_out >= `EBC_CODE_LO);
  endproperty
  a_route: assert property (p_route) else $error("internal access outside region");
  property p_ea_hold;
    !in_rst ##1 !in_rst |-> $stable(ea_r);
  endproperty
  a_ea_hold: assert property (p_ea_hold) else $error("select changed after reset");
  property p_wait_hold;
    s_stall_rise |=> (bst_r == BUS_WAIT) && (wcnt_r == $past(wcnt_r) + 3'd1);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait not held");
  property p_wait_cap;
    (bst_r == BUS_WAIT) |-> (wcnt_r != 3'd0) && (wcnt_r <= wmax);
  endproperty
  a_wait_cap: assert property (p_wait_cap) else $error("wait cap exceeded");
  property p_fixed8;
    ((bst_r == BUS_ADDR) && rise && !ccr0_r[`EBC_CCR0_BW] && chip_config_reg_1_r[`EBC_CHIP_CONFIG_REG_1_BW])
      |=> !is16_r;
  endproperty
  a_fixed8: assert property (p_fixed8) else $error("fixed 8-bit mode ignored");
  property p_wrl;
    (!pins_r.wr_n && ccr0_r[`EBC_CCR0_WRL]) |-> !pins_r.addr[0];
  endproperty
  a_wrl: assert property (p_wrl) else $error("low write strobe on odd byte");
  property p_adv_end;
    ((bst_r == BUS_IDLE) && ccr0_r[`EBC_CCR0_ADV] && $past(ccr0_r[`EBC_CCR0_ADV]))
      |-> pins_r.addr_strobe && pins_r.rd_n && pins_r.wr_n;
  endproperty
  a_adv_end: assert property (p_adv_end) else $error("address valid not released");
endmodule

// ===== logic/ebc_defines.svh
// Constants of the external bus cycle controller: offsets, fields, resets, timing.
// Assumes a 125 MHz core clock; included by the package user files only.
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH

// Timing: core clock and state time in ns, derived cycle counts
`define EBC_CLK_NS        8
`define EBC_ST_NS         16
`define EBC_RST_LOW_ST    16
`define EBC_SEQ_ST        10
`define EBC_RST_LOW_CLKS  ((`EBC_RST_LOW_ST * `EBC_ST_NS + `EBC_CLK_NS - 1) / `EBC_CLK_NS)
`define EBC_SEQ_CLKS      ((`EBC_SEQ_ST * `EBC_ST_NS) / `EBC_CLK_NS)

// Fixed addresses of the post-reset sequence, low 16 bits within the code page
`define EBC_CODE_PAGE     8'hff
`define EBC_CCB0_ADDR     16'h2018
`define EBC_CCB1_ADDR     16'h201a
`define EBC_CCB2_ADDR     16'h201c
`define EBC_START_ADDR    16'h2080

// Code region steered by the latched external-access select
`define EBC_CODE_LO       24'hff2000
`define EBC_CODE_HI       24'hffffff

// Configuration register 0 fields and reset value
`define EBC_CCR0_BW       1
`define EBC_CCR0_WRL      2
`define EBC_CCR0_ADV      3
`define EBC_CCR0_WS_LO    4
`define EBC_CCR0_RDY      6
`define EBC_CCR0_RST      8'h72

// Configuration register 1 fields and reset value
`define EBC_CHIP_CONFIG_REG_1_BW       2
`define EBC_CHIP_CONFIG_REG_1_WS_HI    3
`define EBC_CHIP_CONFIG_REG_1_CCB2_EN  7
`define EBC_CHIP_CONFIG_REG_1_RST      8'h00

`endif

// ===== logic/ebc_pkg.sv
// Types shared by the external bus cycle controller and its surroundings.
// Assumes ebc_defines.svh holds all numeric constants.
package ebc_pkg;

  // Bus cycle states, Gray along idle-address-data-wait
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_DATA = 3'b011,
    BUS_WAIT = 3'b010,
    BUS_INTR = 3'b100
  } ebc_bus_st_t;

  // Reset and start-up states
  typedef enum logic [1:0] {
    RS_RESET = 2'b00,
    RS_SEQ   = 2'b01,
    RS_RUN   = 2'b11
  } ebc_rst_st_t;

  // One memory request from the core
  typedef struct packed {
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebc_req_t;

  // External bus pins (active-low strobes end in _n)
  typedef struct packed {
    logic [23:0] addr;
    logic        byte_address_lsb;
    logic        high_byte_enable_n;
    logic        rd_n;
    logic        wr_n;
    logic        addr_strobe;
    logic [15:0] data;
    logic        data_oe;
  } ebc_bus_pins_t;

endpackage

// ===== verification/ebc_ext_mem.sv
// Far-side model: pattern memory with ready and width pins.
// Assumes registered bus pins from the controller on the same clock.
`timescale 1ns/1ps
module ebc_ext_mem (
  input  wire logic                   clk_in,
  input  wire ebc_pkg::ebc_bus_pins_t bus_in,
  input  wire logic                   stall_in,
  input  wire logic                   wide_in,
  input  wire logic [7:0]             cfg0_in,
  input  wire logic [7:0]             cfg1_in,
  output logic                        ready_out,
  output logic                        width_out,
  output logic [15:0]                 data_out,
  output logic [15:0]                 wdata_out
);
  import ebc_pkg::*;
  logic [15:0] last_r = 16'h0;
  logic [23:0] ev;
  // Byte at an address; config bytes sit at fixed places
  function automatic logic [7:0] mb(input logic [23:0] a);
    if (a[15:0] == 16'h2018) return cfg0_in;
    if (a[15:0] == 16'h201a) return cfg1_in;
    return a[7:0] ^ 8'h3c;
  endfunction
  // Ready is held low while stall is high, over the whole cycle, before any clock fall
  assign ready_out = ~stall_in;
  assign width_out = wide_in;
  assign ev = {bus_in.addr[23:1], 1'b0};
  // Released lanes show the inverse of the last value, never a steady copy
  always_comb begin
    data_out = ~last_r;
    if (!bus_in.rd_n && wide_in) data_out = {mb(ev | 24'h1), mb(ev)};
    else if (!bus_in.rd_n) data_out[7:0] = mb(bus_in.addr);
  end
  // Keep last lane value and the last written word
  always_ff @(posedge clk_in) begin
    last_r <= data_out;
    if (!bus_in.wr_n) wdata_out <= bus_in.data;
  end
endmodule

// ===== verification/tb.sv
// Testbench: boots the controller, then runs bus cycles on a pattern memory.
// Assumes the memory model shares clk_in; no register bus or interrupt.
`timescale 1ns/1ps
module tb;
  import ebc_pkg::*;
  typedef struct {logic [23:0] a; logic w, wd, wide, st; int lat;} ebc_row_t;
  logic          clk_in = 0, arst_n = 0, rpin_n = 0, eas = 0, stall = 0, wide = 1;
  logic          req_v = 0, psw_ld = 0, rdy_o, rdy_oe, bw_o, bw_oe, req_rdy, rsp_v;
  logic          bclk, in_rst, ex_st, m_rdy, m_w, p;
  logic [1:0]    io_v;
  logic [7:0]    cfg0 = 8'h62, cfg1 = 8'h04, c0, c1, c2;
  logic [15:0]   program_status_word = 16'h0, rsp_d, psw_o, m_d, m_wd;
  logic [23:0]   int_a, ex_a;
  ebc_req_t      req = '0;
  ebc_bus_pins_t bus;
  int            fails = 0, cmp_count = 0, lat;
  // Address, write, word, wide memory, stall, latency (0 = not checked)
  ebc_row_t rows[7] = '{
    '{24'hff2100, 0, 1, 1, 0, 5}, '{24'h004203, 0, 0, 1, 0, 5},
    '{24'h004200, 0, 1, 0, 0, 0}, '{24'h004201, 0, 0, 0, 0, 5},
    '{24'h004300, 0, 1, 1, 1, 9}, '{24'h004302, 1, 1, 1, 0, 0},
    '{24'h004305, 0, 0, 0, 1, 9}};

  ebc_bus_ctrl dut (
    .clk_in(clk_in), .arst_n_in(arst_n), .reset_pin_n_in(rpin_n),
    .external_access_select_in(eas), .ready_pin_in(rdy_oe ? rdy_o : m_rdy),
    .ready_pin_out(rdy_o), .ready_pin_oe_out(rdy_oe), .bus_width_pin_in(bw_oe ? bw_o : m_w),
    .bus_width_pin_out(bw_o), .bus_width_pin_oe_out(bw_oe), .low_speed_io_data_in(2'h2),
    .low_speed_io_oe_in(2'h2), .low_speed_io_value_out(io_v), .req_valid_in(req_v),
    .req_in(req), .req_ready_out(req_rdy), .rsp_valid_out(rsp_v), .rsp_rdata_out(rsp_d),
    .int_sel_out(), .int_addr_out(int_a),
    .int_rdata_in({int_a[7:1], 1'b1, int_a[7:1], 1'b0} ^ 16'h3c3c),
    .ext_data_in(m_d), .bus_out(bus), .bus_clock_output_out(bclk), .in_reset_out(in_rst),
    .exec_start_out(ex_st), .exec_addr_out(ex_a), .psw_load_in(psw_ld), .psw_in(program_status_word),
    .program_status_word_out(psw_o), .chip_config_reg_0_out(c0),
    .chip_config_reg_1_out(c1), .chip_config_byte_2_out(c2));
  ebc_ext_mem mem (
    .clk_in(clk_in), .bus_in(bus), .stall_in(stall), .wide_in(wide), .cfg0_in(cfg0),
    .cfg1_in(cfg1), .ready_out(m_rdy), .width_out(m_w), .data_out(m_d), .wdata_out(m_wd));

  // Byte pattern of the far-side model and of the on-chip code memory
  function automatic logic [7:0] bv(input logic [23:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  // Four-state compare, so an unknown never matches
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict, also reached from the watchdog
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One access; pins settle before the request since they pass synchronisers
  task automatic run(input ebc_row_t r);
    logic t;
    t = 0;
    @(posedge clk_in);
    wide <= r.wide;
    stall <= r.st;
    repeat (4) @(posedge clk_in);
    req_v <= 1;
    req <= '{r.w, r.wd, r.a, 16'ha55a};
    while (t !== 1) begin
      @(negedge clk_in);
      t = req_rdy;
      @(posedge clk_in);
    end
    req_v <= 0;
    lat = 0;
    do begin
      @(negedge clk_in);
      lat++;
    end while (rsp_v !== 1 && lat < 100);
    chk(rsp_v, 1);
    if (r.w) chk(m_wd, 16'ha55a);
    else if (r.wd) chk(rsp_d, {bv(r.a + 1), bv(r.a)});
    else chk(rsp_d[7:0], bv(r.a));
    if (r.lat > 0) chk(24'(lat), 24'(r.lat));
  endtask
  // Pin reset of a given length, then the start-up sequence
  task automatic boot(input int low);
    int n;
    n = 0;
    rpin_n <= 0;
    wide <= 1;
    repeat (low) @(posedge clk_in);
    chk(in_rst, 1);
    rpin_n <= 1;
    do begin
      @(posedge clk_in);
      n++;
    end while (ex_st !== 1 && n < 200);
    chk(ex_st, 1);
    chk(n >= 20, 1);
    chk(ex_a, 24'hff2080);
    chk(psw_o, 16'h0);
    chk(c0, cfg0);
    chk(c1, cfg1);
    $display("boot test done");
  endtask

  initial begin
    forever #4 clk_in = ~clk_in;
  end
  // Whole run is a few hundred cycles; this is well over ten times that
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    chk(bw_oe & bw_o, 1);
    arst_n <= 1;
    // Port-pin samples stay clear in power-on reset, so look after it
    repeat (2) @(posedge clk_in);
    chk(io_v[1], 1);
    boot(8);
    chk(bw_oe, 0);
    eas <= 1;
    foreach (rows[i]) run(rows[i]);
    $display("bus cycle table done");
    repeat (4) begin
      p = bclk;
      @(negedge clk_in);
      chk(bclk ^ p, 1);
    end
    @(posedge clk_in);
    psw_ld <= 1;
    program_status_word <= 16'h1234;
    @(posedge clk_in);
    psw_ld <= 0;
    @(posedge clk_in);
    chk(psw_o, 16'h1234);
    $display("clock and status test done");
    // A pin pulse one edge short must not reset
    rpin_n <= 0;
    repeat (31) @(posedge clk_in);
    rpin_n <= 1;
    repeat (3) @(posedge clk_in);
    chk(in_rst, 0);
    // Fixed 8-bit, address-valid strobe, third config byte; select low again
    eas <= 0;
    cfg0 <= 8'h58;
    cfg1 <= 8'h8c;
    boot(33);
    chk(c2, bv(24'hff201c));
    run('{24'h004400, 0, 1, 0, 0, 0});
    run('{24'h004411, 0, 0, 0, 1, 15});
    $display("fixed width test done");
    // Select high at reset: config bytes and code come from on-chip memory
    @(posedge clk_in);
    eas <= 1;
    cfg0 <= bv(24'hff2018);
    cfg1 <= bv(24'hff201a);
    boot(33);
    run('{24'hff2100, 0, 1, 1, 0, 2});
    $display("code routing test done");
    stop_test();
  end
endmodule
